// ===== tlsr_pkg.sv
// constants and carrier types for the thermal limit and status register bank
package tlsr_pkg;

  // register offsets
  localparam logic [7:0] TLSR_OFS_LOW_LIMIT  = 8'h03;
  localparam logic [7:0] TLSR_OFS_CRIT_LIMIT = 8'h04;
  localparam logic [7:0] TLSR_OFS_TEMP       = 8'h05;
  localparam logic [7:0] TLSR_OFS_MAKER      = 8'h06;
  localparam logic [7:0] TLSR_OFS_PART_REV   = 8'h07;
  localparam logic [7:0] TLSR_OFS_RESOL      = 8'h08;

  // field positions
  localparam int TLSR_LIM_HI       = 12;
  localparam int TLSR_LIM_LO       = 2;
  localparam int TLSR_BIT_CRIT     = 15;
  localparam int TLSR_BIT_HIGH     = 14;
  localparam int TLSR_BIT_LOW      = 13;
  localparam int TLSR_RES_FIELD_HI = 4;
  localparam int TLSR_RES_FIELD_LO = 3;

  // reset values
  localparam logic [15:0] TLSR_RST_LIMIT = 16'h0000;
  localparam logic [15:0] TLSR_RST_TEMP  = 16'h0000;
  localparam logic [4:0]  TLSR_RST_RESOL = 5'h0f;

  // resolution codes
  localparam logic [1:0] TLSR_RES_HALF      = 2'h0;
  localparam logic [1:0] TLSR_RES_QUARTER   = 2'h1;
  localparam logic [1:0] TLSR_RES_EIGHTH    = 2'h2;
  localparam logic [1:0] TLSR_RES_SIXTEENTH = 2'h3;

  // hysteresis in quarter degrees (limit lsb)
  localparam logic [11:0] TLSR_HYSTERESIS_SELECT_NONE = 12'h000;
  localparam logic [11:0] TLSR_HYSTERESIS_SELECT_1P5  = 12'h006;
  localparam logic [11:0] TLSR_HYSTERESIS_SELECT_3    = 12'h00c;
  localparam logic [11:0] TLSR_HYSTERESIS_SELECT_6    = 12'h018;

  // timing
  localparam int unsigned TLSR_CLK_HZ       = 100_000_000;
  localparam int unsigned TLSR_CONV_TIME_MS = 100;
  localparam int unsigned TLSR_CONV_CYC     = TLSR_CONV_TIME_MS * (TLSR_CLK_HZ / 1000);
  localparam int          TLSR_CNT_W        = 24;

  // register access request from the serial protocol engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tlsr_req_t;

  // snapshot of one conversion: flags and temperature together
  typedef struct packed {
    logic        crit;
    logic        high;
    logic        low;
    logic [12:0] temp;
  } tlsr_result_t;

endpackage

// ===== tlsr_regs.sv
// thermal limit and status register bank with hysteresis comparators
`timescale 1ns/100ps
// How it works
// - lower limit at offset 03; alarm when temperature below it.
// - window lock set makes lower limit read-only, writes ignored.
// - critical limit at 04; alarm above it until at or below limit minus hysteresis.
// - critical lock set makes critical limit read-only, writes discarded.
// - offset 05 gives signed temperature in bits 12..0, flags in 15..13.
// - bit 15 set above critical, clears at or below critical minus hysteresis.
// - bit 14 set above upper limit, clears at or below upper minus hysteresis.
// - bit 13 set below lower limit, cleared once at or above it.
// - fraction bits finer than selected resolution read as zero.
// - offset 06 returns a fixed 16-bit maker code.
// - offset 07 returns part id high byte, revision low byte.
// - resolution code at bits 4..3 of offset 08, reset value 000f.
// - selected resolution is mirrored into the capabilities field.
// - bits 2..0 of resolution copied to capabilities; host writes ones.
// - a conversion is started and stored within every 100 ms.
// - three synchronised select-address inputs form the low bus address.
// - two-bit hysteresis selects none, 1.5, 3 or 6 degrees.
// - comparisons use only temperature bits 12 down to 2.
// - power-down stops conversions, updates and alarms; bus keeps working.
module tlsr_regs
  import tlsr_pkg::*;
#(
  parameter int unsigned CONV_PERIOD_CYC = TLSR_CONV_CYC,
  parameter logic [15:0] MAKER_CODE      = 16'h1a2b, // arbitrary value
  parameter logic [7:0]  PART_ID         = 8'h5c,    // arbitrary value
  parameter logic [7:0]  REVISION_ID     = 8'h01     // arbitrary value
)
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire tlsr_req_t         req_i,
  output logic                   rd_valid_o,
  output logic [15:0]            rd_data_o,
  input  wire logic [15:0]       upper_limit_i,
  input  wire logic [1:0]        hysteresis_select_i,
  input  wire logic              window_limit_lock_i,
  input  wire logic              critical_limit_lock_i,
  input  wire logic              sensor_power_down_i,
  input  wire logic              alarm_enable_i,
  input  wire logic              critical_only_i,
  output logic                   conv_start_o,
  input  wire logic              sample_valid_i,
  input  wire logic [12:0]       sample_i,
  output logic                   alarm_o,
  output logic [4:0]             cap_mirror_o,
  input  wire logic              select_addr_bit0_i,
  input  wire logic              select_addr_bit1_i,
  input  wire logic              select_addr_bit2_i,
  output logic [2:0]             bus_addr_low_o
);

  // signed compare value from bits 12..2, widened by one bit for subtraction
  function automatic logic signed [11:0] cmp_val(input logic [12:0] v);
    cmp_val = {v[12], v[12:2]};
  endfunction

  logic [10:0]           low_lim_q;
  logic [10:0]           crit_lim_q;
  logic [4:0]            resol_q;
  tlsr_result_t          res_q;
  tlsr_result_t          res_d;
  logic [TLSR_CNT_W-1:0] conv_cnt_q;
  logic [15:0]           rd_data_q;
  logic                  rd_valid_q;
  logic [2:0]            sa_s1_q;
  logic [2:0]            sa_s2_q;
  logic [2:0]            sa_s3_q;
  logic [2:0]            sa_q;

  // write decode; locks gate the limit strobes
  wire wr_low   = ce_i & req_i.wr & (req_i.addr == TLSR_OFS_LOW_LIMIT) & ~window_limit_lock_i;
  wire wr_crit  = ce_i & req_i.wr & (req_i.addr == TLSR_OFS_CRIT_LIMIT) & ~critical_limit_lock_i;
  wire wr_resol = ce_i & req_i.wr & (req_i.addr == TLSR_OFS_RESOL);

  // hysteresis decode
  logic [11:0] hysteresis_select;
  always_comb
  begin
    unique case (hysteresis_select_i)
      2'h0:    hysteresis_select = TLSR_HYSTERESIS_SELECT_NONE;
      2'h1:    hysteresis_select = TLSR_HYSTERESIS_SELECT_1P5;
      2'h2:    hysteresis_select = TLSR_HYSTERESIS_SELECT_3;
      2'h3:    hysteresis_select = TLSR_HYSTERESIS_SELECT_6;
    endcase
  end

  // comparator operands, only bits 12..2 take part
  wire logic signed [11:0] t_cmp    = cmp_val(sample_i);
  wire logic signed [11:0] lo_cmp   = {low_lim_q[10], low_lim_q};
  wire logic signed [11:0] cr_cmp   = {crit_lim_q[10], crit_lim_q};
  wire logic signed [11:0] hi_cmp   = cmp_val(upper_limit_i[12:0]);
  wire logic signed [11:0] cr_thr_h = cr_cmp - $signed(hysteresis_select);
  wire logic signed [11:0] hi_thr_h = hi_cmp - $signed(hysteresis_select);

  // resolution mask: fraction bits below the selected lsb read zero
  wire logic [1:0]  res_code = resol_q[TLSR_RES_FIELD_HI:TLSR_RES_FIELD_LO];
  wire logic [12:0] res_mask = (res_code == TLSR_RES_HALF)    ? 13'h1ff8 :
                               (res_code == TLSR_RES_QUARTER) ? 13'h1ffc :
                               (res_code == TLSR_RES_EIGHTH)  ? 13'h1ffe : 13'h1fff;

  // next snapshot; a held crit or high flag switches to its released threshold
  always_comb
  begin
    res_d.crit = res_q.crit ? (t_cmp > cr_thr_h) : (t_cmp > cr_cmp);
    res_d.high = res_q.high ? (t_cmp > hi_thr_h) : (t_cmp > hi_cmp);
    res_d.low  = (t_cmp < lo_cmp);
    res_d.temp = sample_i & res_mask;
  end

  // conversion pacing; a late adc never widens the gap between starts, so period is the bound
  wire conv_wrap = (conv_cnt_q == TLSR_CNT_W'(CONV_PERIOD_CYC - 1));
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      conv_cnt_q <= '0;
    else if (ce_i & ~sensor_power_down_i)
      conv_cnt_q <= conv_wrap ? '0 : conv_cnt_q + 1'b1;
  end
  assign conv_start_o = ce_i & ~sensor_power_down_i & conv_wrap;

  // limit registers keep only bits 12..2; the rest read as zero
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      low_lim_q  <= TLSR_RST_LIMIT[12:2];
      crit_lim_q <= TLSR_RST_LIMIT[12:2];
      resol_q    <= TLSR_RST_RESOL;
    end
    else
    begin
      if (wr_low)
        low_lim_q <= req_i.wdata[TLSR_LIM_HI:TLSR_LIM_LO];
      if (wr_crit)
        crit_lim_q <= req_i.wdata[TLSR_LIM_HI:TLSR_LIM_LO];
      if (wr_resol)
        resol_q <= req_i.wdata[4:0];
    end
  end

  // value and flags land in one register, so a read never mixes conversions
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      res_q <= tlsr_result_t'(TLSR_RST_TEMP);
    else if (ce_i & sample_valid_i & ~sensor_power_down_i)
      res_q <= res_d;
  end

  // capabilities mirror of test bits and resolution code
  assign cap_mirror_o = resol_q;

  // read mux
  logic [15:0] rd_mux;
  always_comb
  begin
    unique case (req_i.addr)
      TLSR_OFS_LOW_LIMIT:  rd_mux = {3'h0, low_lim_q, 2'h0};
      TLSR_OFS_CRIT_LIMIT: rd_mux = {3'h0, crit_lim_q, 2'h0};
      TLSR_OFS_TEMP:       rd_mux = res_q;
      TLSR_OFS_MAKER:      rd_mux = MAKER_CODE;
      TLSR_OFS_PART_REV:   rd_mux = {PART_ID, REVISION_ID};
      TLSR_OFS_RESOL:      rd_mux = {11'h000, resol_q};
      default:             rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rd_valid_q <= req_i.rd;
      if (req_i.rd)
        rd_data_q <= rd_mux;
    end
  end
  assign rd_data_o  = rd_data_q;
  assign rd_valid_o = rd_valid_q;

  // alarm level; silent in power-down, polarity handled by the pin driver
  assign alarm_o = alarm_enable_i & ~sensor_power_down_i &
                   (res_q.crit | (~critical_only_i & (res_q.high | res_q.low)));

  // select-address pins: three stages, change accepted once stages two and three agree
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sa_s1_q <= 3'h0;
      sa_s2_q <= 3'h0;
      sa_s3_q <= 3'h0;
      sa_q    <= 3'h0;
    end
    else if (ce_i)
    begin
      sa_s1_q <= {select_addr_bit2_i, select_addr_bit1_i, select_addr_bit0_i};
      sa_s2_q <= sa_s1_q;
      sa_s3_q <= sa_s2_q;
      if (sa_s2_q == sa_s3_q)
        sa_q <= sa_s3_q;
    end
  end
  assign bus_addr_low_o = sa_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_low_lock_hold: assert property (ce_i & req_i.wr & (req_i.addr == TLSR_OFS_LOW_LIMIT) & window_limit_lock_i
    |=> low_lim_q == $past(low_lim_q)) else $error("locked lower limit changed");
  a_crit_lock_hold: assert property (ce_i & req_i.wr & (req_i.addr == TLSR_OFS_CRIT_LIMIT) & critical_limit_lock_i
    |=> crit_lim_q == $past(crit_lim_q)) else $error("locked critical limit changed");
  a_crit_flag_set: assert property (ce_i & sample_valid_i & ~sensor_power_down_i & (t_cmp > cr_cmp)
    |=> res_q.crit) else $error("critical flag not set above limit");
  a_high_flag_hysteresis_select: assert property (ce_i & sample_valid_i & ~sensor_power_down_i & res_q.high & (t_cmp <= hi_thr_h)
    |=> ~res_q.high) else $error("upper flag not released");
  a_low_flag_val: assert property (ce_i & sample_valid_i & ~sensor_power_down_i
    |=> res_q.low == ($past(t_cmp) < $past(lo_cmp))) else $error("lower flag wrong");
  a_temp_masked: assert property ((res_code == TLSR_RES_HALF) |-> res_q.temp[1:0] == 2'h0 || $changed(resol_q)
    || !$past(ce_i & sample_valid_i)) else $error("fraction bits not zero");
  a_resol_reset: assert property ($fell(rst_i) |-> resol_q == TLSR_RST_RESOL) else $error("resolution reset wrong");
  a_conv_period: assert property (conv_start_o |=> ~conv_start_o) else $error("conversion start too close");
  a_pdown_quiet: assert property (sensor_power_down_i |-> ~alarm_o & ~conv_start_o
    ##1 (res_q == $past(res_q)) || !$past(sensor_power_down_i)) else $error("activity in power-down");
  a_addr_stable: assert property (ce_i & (sa_s2_q != sa_s3_q) |=> bus_addr_low_o == $past(bus_addr_low_o))
    else $error("address taken before stages agree");
  a_read_ident: assert property (ce_i & req_i.rd & (req_i.addr == TLSR_OFS_MAKER) |=> rd_valid_o
    && rd_data_o == MAKER_CODE) else $error("maker code read wrong");

endmodule

// ===== tlsr_adc_model.sv
// behavioural converter that answers conversion requests of the register bank
`timescale 1ns/100ps
module tlsr_adc_model
  import tlsr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        conv_start_i,
  input  wire logic [12:0] temp_i,
  input  wire logic [3:0]  delay_i,
  output logic             sample_valid_o,
  output logic [12:0]      sample_o
);
  logic       busy_q;
  logic [3:0] cnt_q;

  // answer after a variable delay; between answers the data lines toggle,
  // so a bank that reads them outside the valid pulse gets garbage
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      busy_q         <= 1'b0;
      cnt_q          <= 4'h0;
      sample_valid_o <= 1'b0;
      sample_o       <= 13'h0000;
    end
    else
    begin
      sample_valid_o <= 1'b0;
      sample_o       <= ~sample_o;
      if (conv_start_i)
      begin
        busy_q <= 1'b1;
        cnt_q  <= delay_i;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        busy_q         <= 1'b0;
        sample_valid_o <= 1'b1;
        sample_o       <= temp_i;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ===== thermal_limit_status_regs_bench.sv
// self-checking bench for the thermal limit and status register bank
`timescale 1ns/100ps
module thermal_limit_status_regs_bench;
  import tlsr_pkg::*;
  localparam logic [15:0] MAKER = 16'h4d21; // arbitrary value
  localparam logic [7:0]  PART  = 8'h3e;    // arbitrary value
  localparam logic [7:0]  REV   = 8'h02;    // arbitrary value
  logic        clock_i, rst_i, ce_i, rd_valid_o, conv_start_o, sample_valid_i, alarm_o;
  logic        window_limit_lock_i, critical_limit_lock_i, sensor_power_down_i;
  logic        alarm_enable_i, critical_only_i, ec, eh, el;
  logic        select_addr_bit0_i, select_addr_bit1_i, select_addr_bit2_i;
  tlsr_req_t   req_i;
  logic [15:0] rd_data_o, upper_limit_i, d, lastres;
  logic [12:0] sample_i, temp_set;
  logic [4:0]  cap_mirror_o;
  logic [3:0]  dly;
  logic [2:0]  bus_addr_low_o;
  logic [1:0]  hysteresis_select_i, res;
  logic [31:0] seed = 32'h00e8107c;
  logic [15:0] expq[$];
  int          errors = 0, samples_checked = 0, starts;
  int          tq[14] = '{161, 155, 154, 153, 160, 129, 123, 122, 128, 64, 63, 40, 64, -8};

  tlsr_regs #(.CONV_PERIOD_CYC(20), .MAKER_CODE(MAKER), .PART_ID(PART), .REVISION_ID(REV)) i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .upper_limit_i(upper_limit_i), .hysteresis_select_i(hysteresis_select_i),
    .window_limit_lock_i(window_limit_lock_i), .critical_limit_lock_i(critical_limit_lock_i),
    .sensor_power_down_i(sensor_power_down_i), .alarm_enable_i(alarm_enable_i),
    .critical_only_i(critical_only_i), .conv_start_o(conv_start_o), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .alarm_o(alarm_o), .cap_mirror_o(cap_mirror_o),
    .select_addr_bit0_i(select_addr_bit0_i), .select_addr_bit1_i(select_addr_bit1_i),
    .select_addr_bit2_i(select_addr_bit2_i), .bus_addr_low_o(bus_addr_low_o));
  tlsr_adc_model i_adc (.clock_i(clock_i), .rst_i(rst_i), .conv_start_i(conv_start_o), .temp_i(temp_set),
    .delay_i(dly), .sample_valid_o(sample_valid_i), .sample_o(sample_i));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one request pulse, then an idle edge before the next may start
  task acc(input logic w, input logic [7:0] a, input logic [15:0] dat);
    @(posedge clock_i);
    req_i <= '{wr: w, rd: !w, addr: a, wdata: dat};
    @(posedge clock_i);
    req_i <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back(e);
    acc(1'b0, a, 16'h0000);
  endtask

  // a temperature in quarter degrees with random finer bits; flags tracked here
  task automatic apply(input int q);
    logic [12:0] s;
    int h;
    s = 13'(q * 4) | 13'(rnd() % 4);
    h = (hysteresis_select_i == 2'h0) ? 0 : 6 << (hysteresis_select_i - 2'h1);
    temp_set <= s;
    dly <= 4'(rnd());
    alarm_enable_i <= 1'(rnd());
    critical_only_i <= 1'(rnd());
    starts = 0;
    // the first edge still shows an answer latched before temp_set moved
    while (starts < 100 && !(starts > 1 && sample_valid_i === 1'b1))
    begin
      @(posedge clock_i);
      starts++;
    end
    if (sample_valid_i !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
    @(posedge clock_i);
    #1;
    ec = q > 160 || (ec && q > 160 - h);
    eh = q > 128 || (eh && q > 128 - h);
    el = q < 64;
    chk({15'h0, alarm_o}, {15'h0, alarm_enable_i & (critical_only_i ? ec : ec | eh | el)});
    lastres = {ec, eh, el, s & (13'h1fff << (2'd3 - res))};
    rd(TLSR_OFS_TEMP, lastres);
  endtask

  // read results are compared as they come back, oldest note first
  always @(posedge clock_i)
    if (rd_valid_o === 1'b1)
      chk(rd_data_o, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial
  begin
    {rst_i, ce_i, ec, eh, el, res} = 7'h61;
    {window_limit_lock_i, critical_limit_lock_i, sensor_power_down_i, alarm_enable_i, critical_only_i} = 5'h00;
    {select_addr_bit0_i, select_addr_bit1_i, select_addr_bit2_i, hysteresis_select_i} = 5'h00;
    {req_i, temp_set, dly} = '0;
    upper_limit_i = 16'h0200;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(TLSR_OFS_LOW_LIMIT, 16'h0000);
    rd(TLSR_OFS_CRIT_LIMIT, 16'h0000);
    rd(TLSR_OFS_TEMP, 16'h0000);
    rd(TLSR_OFS_MAKER, MAKER);
    rd(TLSR_OFS_PART_REV, {PART, REV});
    rd(TLSR_OFS_RESOL, 16'h000f);
    rd(8'h09, 16'h0000);
    chk({11'h0, cap_mirror_o}, 16'h000f);
    d = 16'(rnd());
    acc(1'b1, TLSR_OFS_LOW_LIMIT, d);
    acc(1'b1, TLSR_OFS_CRIT_LIMIT, ~d);
    rd(TLSR_OFS_LOW_LIMIT, d & 16'h1ffc);
    rd(TLSR_OFS_CRIT_LIMIT, ~d & 16'h1ffc);
    acc(1'b1, TLSR_OFS_LOW_LIMIT, 16'h0100);
    acc(1'b1, TLSR_OFS_CRIT_LIMIT, 16'h0280);
    window_limit_lock_i <= 1'b1;
    critical_limit_lock_i <= 1'b1;
    acc(1'b1, TLSR_OFS_LOW_LIMIT, d);
    acc(1'b1, TLSR_OFS_CRIT_LIMIT, d);
    acc(1'b1, TLSR_OFS_MAKER, d);
    rd(TLSR_OFS_LOW_LIMIT, 16'h0100);
    rd(TLSR_OFS_CRIT_LIMIT, 16'h0280);
    rd(TLSR_OFS_MAKER, MAKER);
    // each resolution code paired with the hysteresis code of the same value
    for (int h = 0; h < 4; h++)
    begin
      res = 2'(h);
      hysteresis_select_i <= 2'(h);
      acc(1'b1, TLSR_OFS_RESOL, {11'h000, res, 3'b111});
      rd(TLSR_OFS_RESOL, {11'h000, res, 3'b111});
      chk({11'h0, cap_mirror_o}, {11'h000, res, 3'b111});
      foreach (tq[i])
        apply(tq[i]);
    end
    // power-down keeps the old result and silences the alarm
    apply(170);
    sensor_power_down_i <= 1'b1;
    alarm_enable_i <= 1'b1;
    temp_set <= 13'h0000;
    starts = 0;
    repeat (60)
    begin
      @(posedge clock_i);
      starts += (conv_start_o === 1'b1);
    end
    chk(16'(starts), 16'h0000);
    chk({15'h0, alarm_o}, 16'h0000);
    rd(TLSR_OFS_TEMP, lastres);
    sensor_power_down_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      {select_addr_bit2_i, select_addr_bit1_i, select_addr_bit0_i} <= 3'(i);
      repeat (6) @(posedge clock_i);
      chk({13'h0, bus_addr_low_o}, 16'(i));
    end
    // a read while the clock enable is low must not be answered
    ce_i <= 1'b0;
    acc(1'b0, TLSR_OFS_MAKER, 16'h0000);
    ce_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk(16'(expq.size()), 16'h0000);
    print_verdict();
  end
endmodule
